// ---- src/list_seq_defines.vh ----
// constants for the regulation mode and list sequencer block
`ifndef LIST_SEQ_DEFINES_VH
`define LIST_SEQ_DEFINES_VH
// ==========================================
// register offsets
`define OFS_REG_MODE     8'h00
`define OFS_TRIG_MODE    8'h04
`define OFS_OUT_MODE     8'h08
`define OFS_CMD          8'h0C
`define OFS_REPEAT       8'h10
`define OFS_SKIP         8'h14
`define OFS_LIST_CFG     8'h18
`define OFS_CURR_APPEND  8'h1C
`define OFS_CURR_PTR     8'h20
`define OFS_QUERY_START  8'h24
`define OFS_READBACK     8'h28
`define OFS_VOLT_APPEND  8'h2C
`define OFS_DWELL        8'h30
`define OFS_STATUS       8'h34
`define OFS_ERROR        8'h38
// ==========================================
// field positions
`define CMD_LIST_CLEAR   0
`define CMD_PROGRAM_STOP_CMD    1
`define CMD_TRIGGER      2
`define CMD_SAVE         3
`define CMD_RECALL       4
`define CFG_DIR          0
`define CFG_GEN          1
// ==========================================
// encodings and reset values
`define MODE_VOLT        1'h0
`define MODE_CURR        1'h1
`define OUT_OUTPUT_SETTING_A        2'h0
`define OUT_TRANSIENT_OUTPUT_SETTING        2'h1
`define OUT_LIST         2'h2
`define DIR_UP           1'h0
`define GEN_DEFAULT_SEQUENCE         1'h0
`define RST_REPEAT       8'h01
`define RST_SKIP         8'h00
`define RST_DWELL        16'h0001
`define ERR_NONE         16'h0000
`define ERR_CONFLICT     16'hFF23
// ==========================================
// timing and list depth
`define CLK_PERIOD_NS    20
`define DWELL_UNIT_NS    500000
`define LIST_DEPTH       1002
`endif

// ---- src/dwell_timer.v ----
// dwell timer: counts dwell units of list steps and pulses at step end
`timescale 1ns/100ps
`include "list_seq_defines.vh"
module dwell_timer #(
  parameter TICK_CYC = `DWELL_UNIT_NS / `CLK_PERIOD_NS
) (
  input  wire        i_core_clk,
  input  wire        i_reset,
  input  wire        i_run,
  input  wire        i_restart,
  input  wire [15:0] i_dwell,
  output reg         o_step_done
);
  // ==========================================
  // unit divider and step counter
  reg [31:0] div_q;
  reg [15:0] units_q;
  wire       tick;
  wire [15:0] dwell_min;

  assign tick      = (div_q == TICK_CYC - 1);
  assign dwell_min = (i_dwell == 16'h0000) ? 16'h0001 : i_dwell;

  always @(posedge i_core_clk) begin
    if (i_reset || i_restart || !i_run) begin
      div_q       <= 32'h0;
      units_q     <= 16'h0;
      o_step_done <= 1'b0;
    end else begin
      o_step_done <= 1'b0;
      if (tick) begin
        div_q <= 32'h0;
        if (units_q + 16'h1 >= dwell_min) begin
          units_q     <= 16'h0;
          o_step_done <= 1'b1;
        end else begin
          units_q <= units_q + 16'h1;
        end
      end else begin
        div_q <= div_q + 32'h1;
      end
    end
  end
endmodule

// ---- src/output_mode_list_sequencer.v ----
// regulation mode control and current list sequencer
// Operation
// - hold regulation mode, query 0 volt 1 current
// - voltage mode flags current limit error
// - current mode flags voltage limit error
// - mode write forces transient outputs to output_setting_a
// - trigger mode applied on trigger, query 0/1
// - trigger mode write forces transient to output_setting_a
// - trigger mode saved and recalled
// - clear resets pointers, direction, generation, count
// - repeat count 1..255 runs list that often
// - count zero runs until output_setting_a or stop
// - step order follows list direction
// - repeat query returns last written value
// - skip leading steps after first pass
// - skip ignored in reverse direction
// - clear zeroes skip, skip readable
// - append stores at fill location, 1002 deep
// - append with voltage entries posts -221
// - readback gives 16 values from start
// - readback and pointer query post -221
// - fill pointer zeroed by clear, counts up
// - single dwell value applies to all steps
`timescale 1ns/100ps
`include "list_seq_defines.vh"
module output_mode_list_sequencer #(
  parameter DEPTH    = `LIST_DEPTH,
  parameter PTR_W    = 10,
  parameter DATA_W   = 16,
  parameter TICK_CYC = `DWELL_UNIT_NS / `CLK_PERIOD_NS
) (
  input  wire              i_core_clk,
  input  wire              i_reset,
  input  wire [7:0]        i_addr,
  input  wire [31:0]       i_wdata,
  input  wire              i_wr,
  input  wire              i_rd,
  input  wire              i_curr_limit_hit,
  input  wire              i_volt_limit_hit,
  output reg  [31:0]       o_rdata,
  output reg               o_regulation_mode,
  output reg  [DATA_W-1:0] o_main_value,
  output reg               o_list_running,
  output reg               o_limit_error
);
  // ==========================================
  // decode
  function hit;
    input       strobe;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = strobe && (addr == ofs);
    end
  endfunction

  wire wr_mode   = hit(i_wr, i_addr, `OFS_REG_MODE);
  wire wr_trig   = hit(i_wr, i_addr, `OFS_TRIG_MODE);
  wire wr_out    = hit(i_wr, i_addr, `OFS_OUT_MODE);
  wire wr_cmd    = hit(i_wr, i_addr, `OFS_CMD);
  wire wr_rep    = hit(i_wr, i_addr, `OFS_REPEAT);
  wire wr_skip   = hit(i_wr, i_addr, `OFS_SKIP);
  wire wr_cfg    = hit(i_wr, i_addr, `OFS_LIST_CFG);
  wire wr_app    = hit(i_wr, i_addr, `OFS_CURR_APPEND);
  wire wr_qs     = hit(i_wr, i_addr, `OFS_QUERY_START);
  wire wr_vapp   = hit(i_wr, i_addr, `OFS_VOLT_APPEND);
  wire wr_dwell  = hit(i_wr, i_addr, `OFS_DWELL);
  wire rd_ptr    = hit(i_rd, i_addr, `OFS_CURR_PTR);
  wire rd_rb     = hit(i_rd, i_addr, `OFS_READBACK);
  wire rd_err    = hit(i_rd, i_addr, `OFS_ERROR);
  wire cmd_clear = wr_cmd && i_wdata[`CMD_LIST_CLEAR];
  wire cmd_stop  = wr_cmd && i_wdata[`CMD_PROGRAM_STOP_CMD];
  wire cmd_trig  = wr_cmd && i_wdata[`CMD_TRIGGER];
  wire cmd_save  = wr_cmd && i_wdata[`CMD_SAVE];
  wire cmd_rcl   = wr_cmd && i_wdata[`CMD_RECALL];

  // ==========================================
  // state
  reg              trig_mode_q;
  reg              saved_trig_q;
  reg [1:0]        vmode_q;
  reg [1:0]        cmode_q;
  reg [7:0]        repeat_q;
  reg [7:0]        skip_q;
  reg              dir_q;
  reg              gen_q;
  reg [PTR_W-1:0]  cptr_q;
  reg [PTR_W-1:0]  vcnt_q;
  reg [PTR_W-1:0]  qstart_q;
  reg [3:0]        rb_idx_q;
  reg [15:0]       dwell_q;
  reg              conflict_q;
  reg              lim_i_meta_q;
  reg              lim_i_q;
  reg              lim_v_meta_q;
  reg              lim_v_q;
  reg [PTR_W-1:0]  pos_q;
  reg [7:0]        passes_q;
  reg [DATA_W-1:0] table_q [0:DEPTH-1];

  wire volt_busy = (vcnt_q != {PTR_W{1'b0}});
  wire full      = (cptr_q == DEPTH[PTR_W-1:0]);
  wire app_ok    = wr_app && !volt_busy && !full;

  // ==========================================
  // limit inputs, two-stage synchronisers
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      lim_i_meta_q <= 1'b0;
      lim_i_q      <= 1'b0;
      lim_v_meta_q <= 1'b0;
      lim_v_q      <= 1'b0;
    end else begin
      lim_i_meta_q <= i_curr_limit_hit;
      lim_i_q      <= lim_i_meta_q;
      lim_v_meta_q <= i_volt_limit_hit;
      lim_v_q      <= lim_v_meta_q;
    end
  end

  // ==========================================
  // modes
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_regulation_mode <= `MODE_VOLT;
      trig_mode_q       <= `MODE_VOLT;
      saved_trig_q      <= `MODE_VOLT;
    end else begin
      if (wr_mode) begin
        o_regulation_mode <= i_wdata[0];
      end else if (cmd_trig) begin
        o_regulation_mode <= trig_mode_q;
      end
      if (wr_trig) begin
        trig_mode_q <= i_wdata[0];
      end else if (cmd_rcl) begin
        trig_mode_q <= saved_trig_q;
      end
      if (cmd_save) begin
        saved_trig_q <= trig_mode_q;
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      vmode_q <= `OUT_OUTPUT_SETTING_A;
      cmode_q <= `OUT_OUTPUT_SETTING_A;
    end else if (wr_out) begin
      vmode_q <= i_wdata[1:0];
      cmode_q <= i_wdata[3:2];
    end else if (wr_mode || wr_trig) begin
      if (vmode_q == `OUT_TRANSIENT_OUTPUT_SETTING) begin
        vmode_q <= `OUT_OUTPUT_SETTING_A;
      end
      if (cmode_q == `OUT_TRANSIENT_OUTPUT_SETTING) begin
        cmode_q <= `OUT_OUTPUT_SETTING_A;
      end
    end
  end

  // ==========================================
  // limit error flag, set wins over clear
  wire lim_event = (o_regulation_mode == `MODE_VOLT) ? lim_i_q : lim_v_q;
  wire rd_status = hit(i_rd, i_addr, `OFS_STATUS);

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_limit_error <= 1'b0;
    end else if (lim_event) begin
      o_limit_error <= 1'b1;
    end else if (rd_status) begin
      o_limit_error <= 1'b0;
    end
  end

  // ==========================================
  // list settings
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      repeat_q <= `RST_REPEAT;
      skip_q   <= `RST_SKIP;
      dir_q    <= `DIR_UP;
      gen_q    <= `GEN_DEFAULT_SEQUENCE;
      qstart_q <= {PTR_W{1'b0}};
      dwell_q  <= `RST_DWELL;
    end else if (cmd_clear) begin
      repeat_q <= `RST_REPEAT;
      skip_q   <= `RST_SKIP;
      dir_q    <= `DIR_UP;
      gen_q    <= `GEN_DEFAULT_SEQUENCE;
      qstart_q <= {PTR_W{1'b0}};
    end else begin
      if (wr_rep) begin
        repeat_q <= i_wdata[7:0];
      end
      if (wr_skip) begin
        skip_q <= i_wdata[7:0];
      end
      if (wr_cfg) begin
        dir_q <= i_wdata[`CFG_DIR];
        gen_q <= i_wdata[`CFG_GEN];
      end
      if (wr_qs) begin
        qstart_q <= i_wdata[PTR_W-1:0];
      end
      if (wr_dwell) begin
        dwell_q <= i_wdata[15:0];
      end
    end
  end

  // ==========================================
  // fill pointers and table
  always @(posedge i_core_clk) begin
    if (i_reset || cmd_clear) begin
      cptr_q <= {PTR_W{1'b0}};
      vcnt_q <= {PTR_W{1'b0}};
    end else begin
      if (app_ok) begin
        cptr_q <= cptr_q + 1'b1;
      end
      if (wr_vapp && vcnt_q != DEPTH[PTR_W-1:0]) begin
        vcnt_q <= vcnt_q + 1'b1;
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (app_ok) begin
      table_q[cptr_q] <= i_wdata[DATA_W-1:0];
    end
  end

  // ==========================================
  // settings conflict error, set wins over clear
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      conflict_q <= 1'b0;
    end else if (volt_busy && (wr_app || rd_rb || rd_ptr)) begin
      conflict_q <= 1'b1;
    end else if (rd_err) begin
      conflict_q <= 1'b0;
    end
  end

  // ==========================================
  // list sequencer
  wire [PTR_W-1:0] last      = cptr_q - 1'b1;
  wire [PTR_W-1:0] skip_w    = {{(PTR_W-8){1'b0}}, skip_q};
  wire [PTR_W-1:0] up_start  = (skip_w < cptr_q) ? skip_w : {PTR_W{1'b0}};
  wire             start     = wr_out && !o_list_running && cptr_q != {PTR_W{1'b0}}
                               && (i_wdata[1:0] == `OUT_LIST || i_wdata[3:2] == `OUT_LIST);
  wire             stop      = cmd_stop || cmd_clear || (wr_out && !(i_wdata[1:0] == `OUT_LIST
                               || i_wdata[3:2] == `OUT_LIST));
  wire             step_done;
  wire             pass_end  = dir_q ? (pos_q == {PTR_W{1'b0}}) : (pos_q == last);
  wire             final_end = pass_end && repeat_q != 8'h00 && passes_q == 8'h01;
  reg  [PTR_W-1:0] next_pos;
  wire             advance   = o_list_running && step_done && !final_end && !stop;

  always @* begin
    next_pos = pos_q;
    if (start) begin
      next_pos = dir_q ? last : {PTR_W{1'b0}};
    end else if (pass_end) begin
      next_pos = dir_q ? last : up_start;
    end else if (dir_q) begin
      next_pos = pos_q - 1'b1;
    end else begin
      next_pos = pos_q + 1'b1;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_list_running <= 1'b0;
      pos_q          <= {PTR_W{1'b0}};
      passes_q       <= 8'h00;
      o_main_value   <= {DATA_W{1'b0}};
    end else if (stop) begin
      o_list_running <= 1'b0;
    end else if (start) begin
      o_list_running <= 1'b1;
      pos_q          <= next_pos;
      passes_q       <= repeat_q;
      o_main_value   <= table_q[next_pos];
    end else if (o_list_running && step_done) begin
      if (final_end) begin
        o_list_running <= 1'b0;
      end else begin
        pos_q        <= next_pos;
        o_main_value <= table_q[next_pos];
        if (pass_end && repeat_q != 8'h00) begin
          passes_q <= passes_q - 8'h01;
        end
      end
    end
  end

  dwell_timer #(
    .TICK_CYC    (TICK_CYC)
  ) u_dwell (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_run       (o_list_running),
    .i_restart   (start || advance),
    .i_dwell     (dwell_q),
    .o_step_done (step_done)
  );

  // ==========================================
  // readback index
  always @(posedge i_core_clk) begin
    if (i_reset || wr_qs || cmd_clear) begin
      rb_idx_q <= 4'h0;
    end else if (rd_rb) begin
      rb_idx_q <= rb_idx_q + 4'h1;
    end
  end

  // ==========================================
  // read data, one cycle after the strobe
  wire [PTR_W-1:0] rb_loc = qstart_q + {{(PTR_W-4){1'b0}}, rb_idx_q};

  always @(posedge i_core_clk) begin
    if (i_reset || !i_rd) begin
      o_rdata <= 32'h0;
    end else begin
      case (i_addr)
        `OFS_REG_MODE:    o_rdata <= {31'h0, o_regulation_mode};
        `OFS_TRIG_MODE:   o_rdata <= {31'h0, trig_mode_q};
        `OFS_OUT_MODE:    o_rdata <= {28'h0, cmode_q, vmode_q};
        `OFS_REPEAT:      o_rdata <= {24'h0, repeat_q};
        `OFS_SKIP:        o_rdata <= {24'h0, skip_q};
        `OFS_LIST_CFG:    o_rdata <= {30'h0, gen_q, dir_q};
        `OFS_CURR_PTR:    o_rdata <= {{(32-PTR_W){1'b0}}, cptr_q};
        `OFS_QUERY_START: o_rdata <= {{(32-PTR_W){1'b0}}, qstart_q};
        `OFS_READBACK: begin
          if (rb_loc < cptr_q) begin
            o_rdata <= {{(32-DATA_W){1'b0}}, table_q[rb_loc]};
          end else begin
            o_rdata <= 32'h0;
          end
        end
        `OFS_VOLT_APPEND: o_rdata <= {{(32-PTR_W){1'b0}}, vcnt_q};
        `OFS_DWELL:       o_rdata <= {16'h0, dwell_q};
        `OFS_STATUS:      o_rdata <= {29'h0, conflict_q, o_list_running, o_limit_error};
        `OFS_ERROR:       o_rdata <= {16'h0, conflict_q ? `ERR_CONFLICT : `ERR_NONE};
        default:          o_rdata <= 32'h0;
      endcase
    end
  end
endmodule

// ---- sim/output_mode_list_sequencer_asserts.sv ----
// checker for the mode control and list sequencer ports
`timescale 1ns/100ps
`include "list_seq_defines.vh"
module output_mode_list_sequencer_chk #(
  parameter DATA_W = 16
) (
  input wire              i_core_clk,
  input wire              i_reset,
  input wire [7:0]        i_addr,
  input wire [31:0]       i_wdata,
  input wire              i_wr,
  input wire              i_rd,
  input wire              i_curr_limit_hit,
  input wire              i_volt_limit_hit,
  input wire [31:0]       o_rdata,
  input wire              o_regulation_mode,
  input wire [DATA_W-1:0] o_main_value,
  input wire              o_list_running,
  input wire              o_limit_error
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire clr_w = i_wr && i_addr == `OFS_CMD && i_wdata[`CMD_LIST_CLEAR];
  // ==========================================
  // assertions
  chk_mode_read: assert property (i_rd && i_addr == `OFS_REG_MODE
    |=> o_rdata == {31'h0, o_regulation_mode}) else $error("mode read mismatch");
  chk_voltage_output_mode_err: assert property ((i_curr_limit_hit && !o_regulation_mode)[*4]
    |-> o_limit_error) else $error("current limit not flagged");
  chk_current_output_mode_err: assert property ((i_volt_limit_hit && o_regulation_mode)[*4]
    |-> o_limit_error) else $error("voltage limit not flagged");
  chk_transient_output_setting_to_output_setting_a: assert property (i_wr && i_addr == `OFS_REG_MODE
    ##1 (i_rd && i_addr == `OFS_OUT_MODE)
    |=> o_rdata[1:0] != `OUT_TRANSIENT_OUTPUT_SETTING && o_rdata[3:2] != `OUT_TRANSIENT_OUTPUT_SETTING) else $error("transient kept");
  chk_stop_halts: assert property (i_wr && i_addr == `OFS_CMD
    && i_wdata[`CMD_PROGRAM_STOP_CMD] |=> !o_list_running) else $error("list ran on after stop");
  chk_clear_ptr: assert property (clr_w ##1 (i_rd && i_addr == `OFS_CURR_PTR)
    |=> o_rdata == 32'h0) else $error("pointer not cleared");
  chk_clear_count: assert property (clr_w ##1 (i_rd && i_addr == `OFS_REPEAT)
    |=> o_rdata == 32'h1) else $error("repeat not reset to one");
  chk_clear_skip: assert property (clr_w ##1 (i_rd && i_addr == `OFS_SKIP)
    |=> o_rdata == 32'h0) else $error("skip not cleared");
  chk_repeat_echo: assert property (i_wr && i_addr == `OFS_REPEAT
    ##1 (i_rd && i_addr == `OFS_REPEAT)
    |=> o_rdata == {24'h0, $past(i_wdata[7:0], 2)}) else $error("repeat readback wrong");
  cover property ($rose(o_list_running));
  cover property ($fell(o_list_running));
  cover property ($rose(o_limit_error));
endmodule

// ---- sim/host_bus_model.sv ----
// host controller model issuing register commands and queries
`timescale 1ns/100ps
module host_bus_model (
  input  wire         i_core_clk,
  input  wire  [31:0] i_rdata,
  output logic [7:0]  o_addr,
  output logic [31:0] o_wdata,
  output logic        o_wr,
  output logic        o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // write strobe stays up so writes and reads can follow with no gap
  task bus_wr(input [7:0] a, input [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    o_rd <= 1'b0;
  endtask
  task bus_rd(input [7:0] a, output [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wr <= 1'b0;
    o_rd <= 1'b1;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
  task idle;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
  endtask
endmodule

// ---- sim/test_output_mode_list_sequencer.sv ----
// self-checking bench for the mode control and list sequencer
`timescale 1ns/100ps
`include "list_seq_defines.vh"
module test_output_mode_list_sequencer;
  logic        i_core_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_curr_limit_hit = 1'b0;
  logic        i_volt_limit_hit = 1'b0;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, rdv;
  logic        i_wr, i_rd, o_regulation_mode, o_list_running, o_limit_error;
  logic [15:0] o_main_value;
  int          bad_count = 0;
  int          checks_done = 0;
  always #10 i_core_clk = ~i_core_clk;
  output_mode_list_sequencer #(.TICK_CYC(4)) output_mode_list_sequencer_i (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_curr_limit_hit(i_curr_limit_hit),
    .i_volt_limit_hit(i_volt_limit_hit), .o_rdata(o_rdata),
    .o_regulation_mode(o_regulation_mode), .o_main_value(o_main_value),
    .o_list_running(o_list_running), .o_limit_error(o_limit_error));
  host_bus_model host_bus_model_i (.i_core_clk(i_core_clk), .i_rdata(o_rdata),
    .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
  // ==========================================
  // helpers
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    host_bus_model_i.bus_wr(a, d);
  endtask
  task rd_chk(input string nm, input [7:0] a, input [31:0] e);
    host_bus_model_i.bus_rd(a, rdv);
    check(nm, rdv, e);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task pin(input logic c, input logic v, input logic e, input string nm);
    host_bus_model_i.idle;
    i_curr_limit_hit <= c;
    i_volt_limit_hit <= v;
    repeat (6) @(posedge i_core_clk);
    i_curr_limit_hit <= 1'b0;
    i_volt_limit_hit <= 1'b0;
    #1 check(nm, 32'(o_limit_error), 32'(e));
    repeat (4) @(posedge i_core_clk);
    host_bus_model_i.bus_rd(`OFS_STATUS, rdv);
  endtask
  task run_chk(input [95:0] e, input int n);
    logic [15:0] last;
    int k;
    int t0;
    last = 16'hFFFF;
    k = 0;
    t0 = 0;
    wr(`OFS_OUT_MODE, 32'h8);
    host_bus_model_i.idle;
    for (int c = 0; c < 300 && !(k > 0 && o_list_running === 1'b0); c++) begin
      @(posedge i_core_clk);
      #1;
      if (o_list_running === 1'b1 && o_main_value !== last) begin
        if (k < 6) check("step value", o_main_value, e[k*16 +: 16]);
        if (k == 1) t0 = c;
        if (k == 2) check("dwell cycles", c - t0, 5);
        k++;
        last = o_main_value;
      end
    end
    check("step count", k, n);
    check("held value", o_main_value, last);
  endtask
  // ==========================================
  // scenarios
  task t_modes;
    rd_chk("repeat rst", `OFS_REPEAT, 32'h1);
    wr(`OFS_REG_MODE, 32'h1);
    rd_chk("mode cur", `OFS_REG_MODE, 32'h1);
    check("mode pin", 32'(o_regulation_mode), 32'h1);
    wr(`OFS_OUT_MODE, 32'h5);
    wr(`OFS_REG_MODE, 32'h0);
    rd_chk("out output_setting_a", `OFS_OUT_MODE, 32'h0);
    rd_chk("mode volt", `OFS_REG_MODE, 32'h0);
    wr(`OFS_OUT_MODE, 32'h5);
    wr(`OFS_TRIG_MODE, 32'h1);
    rd_chk("trig output_setting_a", `OFS_OUT_MODE, 32'h0);
    rd_chk("trig mode", `OFS_TRIG_MODE, 32'h1);
    wr(`OFS_CMD, 32'h1 << `CMD_SAVE);
    wr(`OFS_TRIG_MODE, 32'h0);
    wr(`OFS_CMD, 32'h1 << `CMD_RECALL);
    rd_chk("trig recall", `OFS_TRIG_MODE, 32'h1);
    wr(`OFS_CMD, 32'h1 << `CMD_TRIGGER);
    rd_chk("trig applied", `OFS_REG_MODE, 32'h1);
  endtask
  task t_limit;
    wr(`OFS_REG_MODE, 32'h0);
    pin(1'b0, 1'b1, 1'b0, "vmode volt hit");
    pin(1'b1, 1'b0, 1'b1, "vmode curr hit");
    rd_chk("err cleared", `OFS_STATUS, 32'h0);
    wr(`OFS_REG_MODE, 32'h1);
    pin(1'b1, 1'b0, 1'b0, "cmode curr hit");
    pin(1'b0, 1'b1, 1'b1, "cmode volt hit");
  endtask
  task t_list;
    wr(`OFS_CMD, 32'h1 << `CMD_LIST_CLEAR);
    wr(`OFS_REG_MODE, 32'h1);
    wr(`OFS_CURR_APPEND, 32'h11);
    wr(`OFS_CURR_APPEND, 32'h22);
    wr(`OFS_CURR_APPEND, 32'h33);
    rd_chk("fill ptr", `OFS_CURR_PTR, 32'h3);
    wr(`OFS_QUERY_START, 32'h0);
    rd_chk("readback 0", `OFS_READBACK, 32'h11);
    rd_chk("readback 1", `OFS_READBACK, 32'h22);
    rd_chk("readback 2", `OFS_READBACK, 32'h33);
    wr(`OFS_DWELL, 32'h1);
    wr(`OFS_SKIP, 32'h1);
    wr(`OFS_REPEAT, 32'h2);
    rd_chk("repeat", `OFS_REPEAT, 32'h2);
    rd_chk("skip", `OFS_SKIP, 32'h1);
    run_chk({16'h33, 16'h22, 16'h33, 16'h22, 16'h11}, 5);
    wr(`OFS_LIST_CFG, 32'h3);
    run_chk({16'h11, 16'h22, 16'h33, 16'h11, 16'h22, 16'h33}, 6);
    wr(`OFS_REPEAT, 32'h0);
    wr(`OFS_OUT_MODE, 32'h8);
    host_bus_model_i.idle;
    repeat (60) @(posedge i_core_clk);
    #1 check("endless", 32'(o_list_running), 32'h1);
    wr(`OFS_CMD, 32'h1 << `CMD_PROGRAM_STOP_CMD);
    rd_chk("stopped", `OFS_STATUS, 32'h0);
    wr(`OFS_OUT_MODE, 32'h8);
    host_bus_model_i.idle;
    #1 check("restarted", 32'(o_list_running), 32'h1);
    wr(`OFS_OUT_MODE, 32'h0);
    rd_chk("output_setting_a stop", `OFS_STATUS, 32'h0);
    wr(`OFS_CMD, 32'h1 << `CMD_LIST_CLEAR);
    rd_chk("clr ptr", `OFS_CURR_PTR, 32'h0);
    wr(`OFS_CMD, 32'h1 << `CMD_LIST_CLEAR);
    rd_chk("clr repeat", `OFS_REPEAT, 32'h1);
    wr(`OFS_CMD, 32'h1 << `CMD_LIST_CLEAR);
    rd_chk("clr skip", `OFS_SKIP, 32'h0);
    rd_chk("clr dir", `OFS_LIST_CFG, 32'h0);
  endtask
  task t_conflict;
    wr(`OFS_VOLT_APPEND, 32'h5);
    wr(`OFS_CURR_APPEND, 32'h44);
    rd_chk("append conflict", `OFS_ERROR, `ERR_CONFLICT);
    rd_chk("error read clr", `OFS_ERROR, 32'h0);
    rd_chk("not stored", `OFS_CURR_PTR, 32'h0);
    rd_chk("ptr conflict", `OFS_ERROR, `ERR_CONFLICT);
    host_bus_model_i.bus_rd(`OFS_READBACK, rdv);
    rd_chk("rb conflict", `OFS_ERROR, `ERR_CONFLICT);
    wr(`OFS_CMD, 32'h1 << `CMD_LIST_CLEAR);
  endtask
  task t_fill;
    for (int i = 0; i < 1003; i++) wr(`OFS_CURR_APPEND, 32'(i));
    rd_chk("full ptr", `OFS_CURR_PTR, 32'd1002);
    wr(`OFS_QUERY_START, 32'd1001);
    rd_chk("last loc", `OFS_READBACK, 32'd1001);
  endtask
  // ==========================================
  // run
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_reset <= 1'b0;
    t_modes;
    t_limit;
    t_list;
    t_conflict;
    t_fill;
    test_done;
  end
  initial begin
    #1000000;
    bad_count++;
    test_done;
  end
endmodule
bind output_mode_list_sequencer output_mode_list_sequencer_chk #(.DATA_W(DATA_W)) chk_i (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_curr_limit_hit(i_curr_limit_hit),
  .i_volt_limit_hit(i_volt_limit_hit), .o_rdata(o_rdata),
  .o_regulation_mode(o_regulation_mode), .o_main_value(o_main_value),
  .o_list_running(o_list_running), .o_limit_error(o_limit_error));
